/* File: hdl/deac_pkg.sv */
// Shared constants and types of the data EEPROM access control block.
package deac_pkg;

	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] DEAC_OFS_LOCATION = 8'h00;
	localparam logic [7:0] DEAC_OFS_BYTE     = 8'h04;
	localparam logic [7:0] DEAC_OFS_CONTROL  = 8'h08;
	localparam logic [7:0] DEAC_OFS_BANK     = 8'h0c;
	localparam logic [7:0] DEAC_OFS_IRQ      = 8'h10;

	// Control register bit positions.
	localparam int DEAC_CTL_PROG_UNLOCK  = 3;
	localparam int DEAC_CTL_PROG_STROBE  = 2;
	localparam int DEAC_CTL_FETCH_UNLOCK = 1;
	localparam int DEAC_CTL_FETCH_STROBE = 0;

	// Interrupt register bit positions.
	localparam int DEAC_IRQ_GLOBAL_EN = 0;
	localparam int DEAC_IRQ_DONE_EN   = 1;
	localparam int DEAC_IRQ_MF_EN     = 2;
	localparam int DEAC_IRQ_DONE_FLAG = 3;
	localparam int DEAC_IRQ_MF_FLAG   = 4;

	// Array geometry.
	localparam int DEAC_ADDR_W = 6;
	localparam int DEAC_DEPTH  = 64;

	// Bank that exposes the control register.
	localparam logic [7:0] DEAC_BANK_CONTROL = 8'h01;

	// Reset values.
	localparam logic [5:0]  DEAC_RST_LOCATION = 6'h00;
	localparam logic [7:0]  DEAC_RST_BYTE     = 8'h00;
	localparam logic [3:0]  DEAC_RST_CONTROL  = 4'h0;
	localparam logic [7:0]  DEAC_RST_BANK     = 8'h00;
	localparam logic [4:0]  DEAC_RST_IRQ      = 5'h00;
	localparam logic [31:0] DEAC_RST_RDATA    = 32'h0000_0000;

	// AHB encodings.
	localparam int         DEAC_HTRANS_ACTIVE = 1;
	localparam logic [1:0] DEAC_HRESP_OKAY    = 2'h0;

	// Sequencer states.
	typedef enum logic [1:0] {
		DEAC_IDLE,
		DEAC_FETCH,
		DEAC_FETCH_DONE,
		DEAC_PROGRAM
	} deac_state_t;

endpackage

/* File: hdl/deac_mem.sv */
// Byte array of the data EEPROM with a registered read port.
`timescale 1ns/100ps
module deac_mem
	import deac_pkg::*;
(
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Write port.
	input  wire logic                   we,
	input  wire logic [DEAC_ADDR_W-1:0] waddr,
	input  wire logic [7:0]             wdata,
	// Read port.
	input  wire logic [DEAC_ADDR_W-1:0] raddr,
	output logic      [7:0]             rdata_reg
);

	// Storage cells; contents are not reset, as a real array keeps them.
	logic [7:0] cells [DEAC_DEPTH];

	// The array takes a write on every rising clock edge that sees the write enable high.
	always_ff @(posedge clk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	// Read data always comes out of a register, one cycle after the address.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= DEAC_RST_BYTE;
		end else begin
			rdata_reg <= cells[raddr];
		end
	end

endmodule // deac_mem

/* File: hdl/deac_top.sv */
// Data EEPROM access control with an AHB-Lite register slave.
//
// Summary of operation
// - Program strobe ignored unless program unlock set.
// - Write duration set by asynchronous external timer.
// - Hardware clears program strobe when write ends.
// - Program unlock is cleared at reset.
// - Bank select resets to zero, hiding control.
// - Write end sets done and multi-function flags.
// - Vector request needs all enables, stack free.
// - Service clears multi-function flag only.
// - Fetch: unlock, strobe, poll, then read byte.
// - Sixty-four bytes; location upper bits read zero.
// - Control bit layout; upper bits read zero.
// - Fetched byte held until next operation.
`timescale 1ns/100ps
module deac_top
	import deac_pkg::*;
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave port.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	output logic      [31:0] hrdata,
	// Write timer handshake.
	output logic             nv_write_start,
	input  wire logic        nv_timer_done,
	// Interrupt controller side.
	input  wire logic        stack_full,
	input  wire logic        irq_service_ack,
	output logic             irq_vector_req
);

	// Bus state: pending data phases, latched address, answer registers.
	logic        wr_pend_reg, wr_pend_next;
	logic        rd_pend_reg, rd_pend_next;
	logic [7:0]  addr_reg, addr_next;
	logic        hready_reg, hready_next;
	logic [31:0] hrdata_reg, hrdata_next;

	// Software visible registers.
	logic [5:0]  nv_location_reg, nv_location_next;
	logic [7:0]  nv_byte_reg, nv_byte_next;
	logic [3:0]  nv_control_reg, nv_control_next;
	logic [7:0]  bank_select_reg, bank_select_next;
	logic [4:0]  irq_reg, irq_next;

	// Sequencer and its outputs.
	deac_state_t state_reg, state_next;
	logic        start_reg, start_next;
	logic        vector_reg, vector_next;

	// Completion synchroniser; stage one feeds stage two only.
	logic        done_s1_reg, done_s2_reg, done_s3_reg;
	logic        done_rise;

	// Memory port signals.
	logic        mem_we;
	logic [7:0]  mem_rdata;

	// Helper terms.
	logic        bus_accept;
	logic        bus_write;
	logic        ctl_visible;
	logic [31:0] read_value;

	assign bus_accept  = hsel && htrans[DEAC_HTRANS_ACTIVE] && hready;
	assign bus_write   = wr_pend_reg && hready_reg;
	assign ctl_visible = (bank_select_reg == DEAC_BANK_CONTROL);
	assign done_rise   = done_s2_reg && !done_s3_reg;

	// Read multiplexer; unused bits of every register read as zero.
	always_comb begin
		read_value = 32'h0000_0000;
		case (addr_reg)
			DEAC_OFS_LOCATION: read_value[5:0] = nv_location_reg;
			DEAC_OFS_BYTE:     read_value[7:0] = nv_byte_reg;
			DEAC_OFS_CONTROL: begin
				// Hidden while another bank is selected.
				if (ctl_visible) begin
					read_value[3:0] = nv_control_reg;
				end
			end
			DEAC_OFS_BANK:     read_value[7:0] = bank_select_reg;
			DEAC_OFS_IRQ:      read_value[4:0] = irq_reg;
			default:           read_value = 32'h0000_0000;
		endcase
	end

	// Bus handshake: writes finish with no wait, reads take one wait state
	// so the answer is registered from values updated by a prior write.
	always_comb begin
		wr_pend_next = 1'b0;
		rd_pend_next = 1'b0;
		addr_next    = addr_reg;
		hready_next  = 1'b1;
		hrdata_next  = hrdata_reg;
		if (rd_pend_reg) begin
			// Wait state of a read: the answer is loaded here.
			hrdata_next = read_value;
		end else if (bus_accept) begin
			// Address phase taken; reads stall one cycle.
			addr_next    = haddr[7:0];
			wr_pend_next = hwrite;
			rd_pend_next = !hwrite;
			hready_next  = hwrite;
		end
	end

	// Bus registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hready_reg  <= 1'b1;
			hrdata_reg  <= DEAC_RST_RDATA;
		end else begin
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			addr_reg    <= addr_next;
			hready_reg  <= hready_next;
			hrdata_reg  <= hrdata_next;
		end
	end

	// Two stage synchroniser on the asynchronous timer completion, plus a
	// third stage so only settled values reach the edge detector.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
			done_s3_reg <= 1'b0;
		end else begin
			done_s1_reg <= nv_timer_done;
			done_s2_reg <= done_s1_reg;
			done_s3_reg <= done_s2_reg;
		end
	end

	// Registers and sequencer. Bus writes come first, hardware events
	// after, so a hardware set beats a software clear in the same cycle.
	always_comb begin
		nv_location_next = nv_location_reg;
		nv_byte_next     = nv_byte_reg;
		nv_control_next  = nv_control_reg;
		bank_select_next = bank_select_reg;
		irq_next         = irq_reg;
		state_next       = state_reg;
		start_next       = start_reg;
		mem_we           = 1'b0;
		if (bus_write) begin
			case (addr_reg)
				DEAC_OFS_LOCATION: nv_location_next = hwdata[5:0];
				DEAC_OFS_BYTE:     nv_byte_next = hwdata[7:0];
				DEAC_OFS_BANK:     bank_select_next = hwdata[7:0];
				DEAC_OFS_CONTROL: begin
					if (ctl_visible) begin
						nv_control_next[DEAC_CTL_PROG_UNLOCK] =
							hwdata[DEAC_CTL_PROG_UNLOCK];
						nv_control_next[DEAC_CTL_FETCH_UNLOCK] =
							hwdata[DEAC_CTL_FETCH_UNLOCK];
						// A strobe sets only if its unlock was already set;
						// software cannot clear a strobe.
						nv_control_next[DEAC_CTL_PROG_STROBE] =
							nv_control_reg[DEAC_CTL_PROG_STROBE] ||
							(hwdata[DEAC_CTL_PROG_STROBE] &&
							 nv_control_reg[DEAC_CTL_PROG_UNLOCK] &&
							 !hwdata[DEAC_CTL_FETCH_STROBE]);
						nv_control_next[DEAC_CTL_FETCH_STROBE] =
							nv_control_reg[DEAC_CTL_FETCH_STROBE] ||
							(hwdata[DEAC_CTL_FETCH_STROBE] &&
							 nv_control_reg[DEAC_CTL_FETCH_UNLOCK] &&
							 !hwdata[DEAC_CTL_PROG_STROBE]);
					end
				end
				DEAC_OFS_IRQ: begin
					irq_next[DEAC_IRQ_GLOBAL_EN] = hwdata[DEAC_IRQ_GLOBAL_EN];
					irq_next[DEAC_IRQ_DONE_EN]   = hwdata[DEAC_IRQ_DONE_EN];
					irq_next[DEAC_IRQ_MF_EN]     = hwdata[DEAC_IRQ_MF_EN];
					// Flags are cleared by writing zero; one leaves them.
					irq_next[DEAC_IRQ_DONE_FLAG] = irq_reg[DEAC_IRQ_DONE_FLAG] &&
						hwdata[DEAC_IRQ_DONE_FLAG];
					irq_next[DEAC_IRQ_MF_FLAG] = irq_reg[DEAC_IRQ_MF_FLAG] &&
						hwdata[DEAC_IRQ_MF_FLAG];
				end
				default: begin
					// Unmapped offsets ignore writes.
				end
			endcase
		end
		// Servicing the vector clears only the multi-function flag.
		if (irq_service_ack) begin
			irq_next[DEAC_IRQ_MF_FLAG] = 1'b0;
		end
		case (state_reg)
			DEAC_IDLE: begin
				// Strobes are never both set while idle, so the order is arbitrary.
				if (nv_control_reg[DEAC_CTL_PROG_STROBE]) begin
					state_next = DEAC_PROGRAM;
					start_next = 1'b1;
				end else if (nv_control_reg[DEAC_CTL_FETCH_STROBE]) begin
					state_next = DEAC_FETCH;
				end
			end
			DEAC_FETCH: begin
				// The array registers the byte at the location this cycle.
				state_next = DEAC_FETCH_DONE;
			end
			DEAC_FETCH_DONE: begin
				nv_byte_next = mem_rdata;
				nv_control_next[DEAC_CTL_FETCH_STROBE] = 1'b0;
				state_next = DEAC_IDLE;
			end
			DEAC_PROGRAM: begin
				// The cycle lasts as long as the external timer decides;
				// the sequencer only waits for its completion.
				if (done_rise) begin
					mem_we = 1'b1;
					start_next = 1'b0;
					nv_control_next[DEAC_CTL_PROG_STROBE] = 1'b0;
					irq_next[DEAC_IRQ_DONE_FLAG] = 1'b1;
					irq_next[DEAC_IRQ_MF_FLAG]   = 1'b1;
					state_next = DEAC_IDLE;
				end
			end
			default: begin
				state_next = DEAC_IDLE;
				start_next = 1'b0;
			end
		endcase
		// Vector request needs every enable and room on the stack.
		vector_next = irq_reg[DEAC_IRQ_GLOBAL_EN] &&
			irq_reg[DEAC_IRQ_DONE_EN] && irq_reg[DEAC_IRQ_MF_EN] &&
			irq_reg[DEAC_IRQ_MF_FLAG] && !stack_full;
	end

	// Register state; reset clears unlocks and bank select.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nv_location_reg <= DEAC_RST_LOCATION;
			nv_byte_reg     <= DEAC_RST_BYTE;
			nv_control_reg  <= DEAC_RST_CONTROL;
			bank_select_reg <= DEAC_RST_BANK;
			irq_reg         <= DEAC_RST_IRQ;
			state_reg       <= DEAC_IDLE;
			start_reg       <= 1'b0;
			vector_reg      <= 1'b0;
		end else begin
			nv_location_reg <= nv_location_next;
			nv_byte_reg     <= nv_byte_next;
			nv_control_reg  <= nv_control_next;
			bank_select_reg <= bank_select_next;
			irq_reg         <= irq_next;
			state_reg       <= state_next;
			start_reg       <= start_next;
			vector_reg      <= vector_next;
		end
	end

	// The array stores the byte register at the location register.
	deac_mem i_deac_mem (
		.clk       (hclk),
		.rst_n     (hresetn),
		.we        (mem_we),
		.waddr     (nv_location_reg),
		.wdata     (nv_byte_reg),
		.raddr     (nv_location_reg),
		.rdata_reg (mem_rdata)
	);

	// Outputs come straight from flip-flops; the response is always OKAY.
	assign hreadyout      = hready_reg;
	assign hresp          = DEAC_HRESP_OKAY;
	assign hrdata         = hrdata_reg;
	assign nv_write_start = start_reg;
	assign irq_vector_req = vector_reg;

	// A program strobe only rises while the unlock was already set.
	chk_strobe_locked: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(nv_control_reg[DEAC_CTL_PROG_STROBE]) |->
			$past(nv_control_reg[DEAC_CTL_PROG_UNLOCK]))
		else $error("program strobe rose without unlock");

	// Completion clears the strobe and drops the start request.
	chk_done_clears: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == DEAC_PROGRAM && done_rise) |=>
			!nv_control_reg[DEAC_CTL_PROG_STROBE] && !nv_write_start)
		else $error("program strobe not cleared at completion");

	// Completion raises both request flags.
	chk_done_flags: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == DEAC_PROGRAM && done_rise) |=>
			irq_reg[DEAC_IRQ_DONE_FLAG] && irq_reg[DEAC_IRQ_MF_FLAG])
		else $error("done flags not set at completion");

	// Completion is seen only after passing the synchroniser stages.
	chk_sync_path: assert property (
		@(posedge hclk) disable iff (!hresetn)
		done_rise |-> $past(nv_timer_done, 2) && !$past(nv_timer_done, 3))
		else $error("completion edge not synchronised");

	// Right after reset release unlocks and bank are zero.
	chk_reset_state: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> nv_control_reg == DEAC_RST_CONTROL &&
			bank_select_reg == DEAC_RST_BANK)
		else $error("control or bank not cleared by reset");

	// Vector request follows the gating terms of the previous cycle.
	chk_vector_gate: assert property (
		@(posedge hclk) disable iff (!hresetn)
		##1 irq_vector_req == $past(irq_reg[DEAC_IRQ_GLOBAL_EN] &&
			irq_reg[DEAC_IRQ_DONE_EN] && irq_reg[DEAC_IRQ_MF_EN] &&
			irq_reg[DEAC_IRQ_MF_FLAG] && !stack_full))
		else $error("vector request gating wrong");

	// Service clears the multi-function flag and keeps the done flag.
	chk_service_clear: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(irq_service_ack && !done_rise &&
		 !(bus_write && addr_reg == DEAC_OFS_IRQ)) |=>
			!irq_reg[DEAC_IRQ_MF_FLAG] &&
			irq_reg[DEAC_IRQ_DONE_FLAG] == $past(irq_reg[DEAC_IRQ_DONE_FLAG]))
		else $error("service cleared wrong flag");

	// Location readback carries zeros above the six location bits.
	chk_location_pad: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_pend_reg && addr_reg == DEAC_OFS_LOCATION) |=>
			hreadyout && hrdata[31:6] == 26'h0 &&
			hrdata[5:0] == $past(nv_location_reg))
		else $error("location readback wrong");

	// Control readback is zero above bit three, and zero when hidden.
	chk_control_pad: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_pend_reg && addr_reg == DEAC_OFS_CONTROL) |=>
			hrdata[31:4] == 28'h0 &&
			hrdata[3:0] == ($past(ctl_visible) ? $past(nv_control_reg) : 4'h0))
		else $error("control readback wrong");

	// A fetch strobe is cleared exactly three cycles after it rises.
	chk_fetch_time: assert property (
		@(posedge hclk) disable iff (!hresetn)
		($rose(nv_control_reg[DEAC_CTL_FETCH_STROBE]) &&
		 state_reg == DEAC_IDLE) |->
			nv_control_reg[DEAC_CTL_FETCH_STROBE] [*3]
			##1 !nv_control_reg[DEAC_CTL_FETCH_STROBE])
		else $error("fetch strobe timing wrong");

	// The byte register changes only on a fetch or a bus write to it.
	chk_byte_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$changed(nv_byte_reg) |-> $past(state_reg == DEAC_FETCH_DONE ||
			(bus_write && addr_reg == DEAC_OFS_BYTE)))
		else $error("byte register changed spuriously");

endmodule // deac_top

/* File: testbench/deac_timer_model.sv */
// Behavioural model of the asynchronous write timer beside the block.
`timescale 1ns/100ps
module deac_timer_model (
	// Handshake with the block.
	input  wire logic        nv_write_start,
	output logic             nv_timer_done,
	// Write duration in ns, chosen by the bench.
	input  wire logic [15:0] delay_ns
);
	// Done is a level that starts low.
	initial nv_timer_done = 1'b0;

	// The odd fraction keeps done off the clock grid, as a free timer is.
	always @(posedge nv_write_start) begin
		#(delay_ns + 0.3);
		nv_timer_done = 1'b1;
		// Held past the sync window so the block cannot miss the edge.
		@(negedge nv_write_start);
		#40.3;
		nv_timer_done = 1'b0;
	end
endmodule // deac_timer_model

/* File: testbench/test_data_eeprom_access_control.sv */
// Self-checking bench for the data EEPROM access control block.
`timescale 1ns/100ps
module test_data_eeprom_access_control;
	import deac_pkg::*;

	// Clock, reset and bus master signals.
	logic        hclk            = 1'b0;
	logic        hresetn         = 1'b0;
	logic        hsel            = 1'b0;
	logic [31:0] haddr           = 32'h0000_0000;
	logic [1:0]  htrans          = 2'h0;
	logic        hwrite          = 1'b0;
	logic [2:0]  hsize           = 3'h2;
	logic [31:0] hwdata          = 32'h0000_0000;
	logic        hreadyout;
	logic [1:0]  hresp;
	logic [31:0] hrdata;
	// Timer handshake and interrupt side.
	logic        nv_write_start;
	logic        nv_timer_done;
	logic [15:0] delay_ns        = 16'h0064;
	logic        stack_full      = 1'b0;
	logic        irq_service_ack = 1'b0;
	logic        irq_vector_req;
	// Bookkeeping.
	int          error_cnt       = 0;
	int          samples_checked = 0;
	int          cyc             = 0;

	// An 8 ns clock.
	always #4 hclk = ~hclk;

	// The block under test; its own ready closes the bus loop.
	deac_top i_deac_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata),
		.nv_write_start(nv_write_start), .nv_timer_done(nv_timer_done),
		.stack_full(stack_full), .irq_service_ack(irq_service_ack),
		.irq_vector_req(irq_vector_req)
	);

	// The far-side write timer.
	deac_timer_model i_deac_timer_model (
		.nv_write_start(nv_write_start),
		.nv_timer_done(nv_timer_done),
		.delay_ns(delay_ns)
	);

	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the few hundred cycles needed.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// Compares four-state values and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One single transfer; entered and left right after a rising edge.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	// Register read compared with an expected word.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0000_0000, x);
		chk(x, e);
	endtask

	// Reads control until the masked strobe has cleared.
	task automatic poll(input logic [31:0] m);
		logic [31:0] x;
		x = m;
		while ((x & m) !== 32'h0000_0000) begin
			xfer(1'b0, DEAC_OFS_CONTROL, 32'h0000_0000, x);
		end
	endtask

	// Reset values, the hidden control register and an unmapped slot.
	task automatic t_reset;
		rd_chk(DEAC_OFS_LOCATION, 32'h0000_0000);
		rd_chk(DEAC_OFS_BYTE, 32'h0000_0000);
		rd_chk(DEAC_OFS_BANK, 32'h0000_0000);
		rd_chk(DEAC_OFS_IRQ, 32'h0000_0000);
		rd_chk(DEAC_OFS_CONTROL, 32'h0000_0000);
		wr(DEAC_OFS_BANK, 32'h0000_0001);
		rd_chk(DEAC_OFS_CONTROL, 32'h0000_0000);
		wr(DEAC_OFS_BANK, 32'h0000_0000);
		rd_chk(8'h14, 32'h0000_0000);
	endtask

	// A full write with interrupt handling; dly sets the timer.
	task automatic t_program(input logic [7:0] loc, input logic [7:0] dat,
		input logic [15:0] dly);
		delay_ns <= dly;
		wr(DEAC_OFS_LOCATION, {24'h00_0000, loc});
		wr(DEAC_OFS_BYTE, {24'h00_0000, dat});
		wr(DEAC_OFS_BANK, 32'h0000_0001);
		wr(DEAC_OFS_IRQ, 32'h0000_0006);
		wr(DEAC_OFS_CONTROL, 32'h0000_0008);
		wr(DEAC_OFS_CONTROL, 32'h0000_000c);
		repeat (2) @(posedge hclk);
		chk({31'h0, nv_write_start}, 32'h0000_0001);
		wr(DEAC_OFS_IRQ, 32'h0000_0007);
		// A slow timer leaves the strobe visibly pending.
		if (dly > 16'h00c8) begin
			rd_chk(DEAC_OFS_CONTROL, 32'h0000_000c);
		end
		poll(32'h0000_0004);
		chk({31'h0, nv_write_start}, 32'h0000_0000);
		rd_chk(DEAC_OFS_IRQ, 32'h0000_001f);
		chk({31'h0, irq_vector_req}, 32'h0000_0001);
		// A full stack holds the vector request back.
		stack_full <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, irq_vector_req}, 32'h0000_0000);
		stack_full <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({31'h0, irq_vector_req}, 32'h0000_0001);
		// Service clears the parent flag only.
		irq_service_ack <= 1'b1;
		@(posedge hclk);
		irq_service_ack <= 1'b0;
		rd_chk(DEAC_OFS_IRQ, 32'h0000_000f);
		chk({31'h0, irq_vector_req}, 32'h0000_0000);
		wr(DEAC_OFS_IRQ, 32'h0000_0007);
		rd_chk(DEAC_OFS_IRQ, 32'h0000_0007);
		wr(DEAC_OFS_CONTROL, 32'h0000_0000);
		wr(DEAC_OFS_BANK, 32'h0000_0000);
	endtask

	// Field widths, bank gating and a strobe without its unlock.
	task automatic t_fields;
		wr(DEAC_OFS_LOCATION, 32'hffff_ffff);
		rd_chk(DEAC_OFS_LOCATION, 32'h0000_003f);
		wr(DEAC_OFS_BYTE, 32'hffff_ffff);
		rd_chk(DEAC_OFS_BYTE, 32'h0000_00ff);
		wr(DEAC_OFS_CONTROL, 32'h0000_0008);
		wr(DEAC_OFS_BANK, 32'h0000_0001);
		rd_chk(DEAC_OFS_CONTROL, 32'h0000_0000);
		wr(DEAC_OFS_CONTROL, 32'h0000_00f0);
		rd_chk(DEAC_OFS_CONTROL, 32'h0000_0000);
		wr(DEAC_OFS_CONTROL, 32'h0000_0004);
		repeat (2) @(posedge hclk);
		chk({31'h0, nv_write_start}, 32'h0000_0000);
		rd_chk(DEAC_OFS_CONTROL, 32'h0000_0000);
		// A fetch strobe without its unlock must not start a fetch.
		wr(DEAC_OFS_CONTROL, 32'h0000_0001);
		rd_chk(DEAC_OFS_CONTROL, 32'h0000_0000);
		rd_chk(DEAC_OFS_BYTE, 32'h0000_00ff);
		wr(DEAC_OFS_BANK, 32'h0000_0000);
	endtask

	// A fetch, then the fetched byte must survive a location change.
	task automatic t_fetch(input logic [7:0] loc, input logic [7:0] exp);
		wr(DEAC_OFS_LOCATION, {24'h00_0000, loc});
		wr(DEAC_OFS_BYTE, {24'h00_0000, ~exp});
		wr(DEAC_OFS_BANK, 32'h0000_0001);
		wr(DEAC_OFS_CONTROL, 32'h0000_0002);
		wr(DEAC_OFS_CONTROL, 32'h0000_0003);
		poll(32'h0000_0001);
		rd_chk(DEAC_OFS_BYTE, {24'h00_0000, exp});
		// The answer to the byte read must carry an OKAY response.
		chk({30'h0, hresp}, {30'h0, DEAC_HRESP_OKAY});
		wr(DEAC_OFS_LOCATION, {24'h00_0000, loc ^ 8'h01});
		rd_chk(DEAC_OFS_BYTE, {24'h00_0000, exp});
		wr(DEAC_OFS_CONTROL, 32'h0000_0000);
		wr(DEAC_OFS_BANK, 32'h0000_0000);
	endtask

	// Main sequence: reset, then slow and prompt writes with read-back.
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_program(8'h3f, 8'ha5, 16'h0190);
		t_fields();
		t_fetch(8'h3f, 8'ha5);
		t_program(8'h00, 8'h5a, 16'h0014);
		t_fetch(8'h00, 8'h5a);
		complete_run();
	end
endmodule // test_data_eeprom_access_control
